// file: logic/wwd_top.sv
// window watchdog: 7-bit downcounter, window check, reset request
// assumes aclk is the oscillator-derived clock; registers over AXI4-Lite
// sys_reset_req only requests a reset; the system is expected to answer with aresetn
// Notes on behaviour
// RULE1 - counter drops by one every 16384 clocks via free-running prescaler
// RULE2 - counter keeps counting while inactive; no reset from expiry then
// RULE3 - active and counter passing 40h to 3Fh starts a reset
// RULE4 - active and reload while count above window limit gives reset
// RULE5 - software reloads only when count below window and above 3Fh
// RULE6 - software writes C0h to FFh when refreshing
// RULE7 - control writes must set counter bit 6, else immediate reset
// RULE8 - software activation: off after reset, set by software, sticks
// RULE9 - hardware activation option: always active, activation bit ignored
// RULE10 - activation bit set with counter bit 6 clear resets at once
// RULE11 - active plus halt-reset option: halt instruction gives reset
// RULE12 - low six counter bits choose timeout in 64 prescaler steps
// RULE13 - first decrement after write comes at unknown prescaler phase
// RULE14 - software should refresh before halt when halt is allowed
// RULE15 - control holds activation bit 7, counter 6:0; both reset 7Fh
// RULE16 - activation bit set by software, cleared only by reset
// RULE17 - oscillator irq enable clear and halt option set: halt resets
// RULE18 - counter compared with window bits 6:0 at each control write
// RULE19 - control write loads counter and decrementing restarts there
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
module wwd_top
   import wwd_pkg::*;
#(
   parameter int unsigned ADDR_W = 12,
   parameter int unsigned PRESC_DIV = WWD_PRESC_CYCLES,
   parameter int unsigned RST_HOLD = WWD_RST_HOLD_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic halt_exec,
   output logic sys_reset_req
);
   localparam int HW = $clog2(RST_HOLD + 1);
   localparam logic [HW-1:0] HOLD_LAST = HW'(RST_HOLD - 1);

   typedef struct packed {
      wwd_fsm_t fsm;
      logic [HW-1:0] hold;
      logic sys_rst;
      logic [3:0] cause;
      logic activation_bit;
      logic [6:0] cnt;
      logic [6:0] win;
      logic hw_opt;
      logic halt_reset_option;
      logic oscillator_irq_enable;
      logic aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } wwd_state_t;

   wwd_state_t s_r;
   wwd_state_t s_nxt;

   logic tick;
   logic aw_take;
   logic w_take;
   logic do_wr;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wd;
   logic wr_lane0;
   logic ctrl_wr;
   logic active;
   logic active_after;
   logic [3:0] trig;

   generate
      // the pulse and tick checks below count eight cycles by repetition
      if (RST_HOLD < 8 || PRESC_DIV < 9) begin : g_bad_timing
         $error("reset hold below 8 or prescaler divider below 9");
      end
      // the decoder compares the address bits above the low nibble with zero
      if (ADDR_W < 5) begin : g_bad_addr
         $error("address width below 5 bits");
      end
   endgenerate

   // RULE1
   wwd_prescaler #(.DIV(PRESC_DIV)) wwd_prescaler_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   function automatic logic wwd_hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
      wwd_hit = (a[ADDR_W-1:4] == '0) && (a[3:0] == off);
   endfunction : wwd_hit

   function automatic logic wwd_mapped(input logic [ADDR_W-1:0] a);
      wwd_mapped = wwd_hit(a, WWD_ADDR_CTRL) || wwd_hit(a, WWD_ADDR_WIN) ||
                   wwd_hit(a, WWD_ADDR_OPT) || wwd_hit(a, WWD_ADDR_STAT);
   endfunction : wwd_mapped

   assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
   assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
   assign s_axi_arready = !s_r.rvalid;

   always_comb begin
      s_nxt = s_r;
      aw_take = s_axi_awvalid && s_axi_awready;
      w_take = s_axi_wvalid && s_axi_wready;
      wr_addr = s_r.aw_got ? s_r.aw_addr : s_axi_awaddr;
      wd = s_r.w_got ? s_r.w_data : s_axi_wdata;
      wr_lane0 = s_r.w_got ? s_r.w_lane0 : s_axi_wstrb[0];
      do_wr = (s_r.aw_got || aw_take) && (s_r.w_got || w_take);
      ctrl_wr = do_wr && wr_lane0 && wwd_hit(wr_addr, WWD_ADDR_CTRL);
      active = s_r.activation_bit || s_r.hw_opt; // RULE9
      // a write that sets the activation bit is judged as already active
      active_after = active || (ctrl_wr && wd[WWD_ACT_BIT]);
      trig = 4'h0;
      if (aw_take) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (w_take) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_lane0 = s_axi_wstrb[0];
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // counter runs whether or not the watchdog is active
      if (tick) begin
         s_nxt.cnt = s_r.cnt - 7'h01; // RULE1 RULE2
         if (active && s_r.cnt == WWD_CNT_EXPIRE) begin
            trig = trig | WWD_CAUSE_EXPIRE; // RULE3
         end
      end
      if (halt_exec && active && s_r.halt_reset_option && !s_r.oscillator_irq_enable) begin
         trig = trig | WWD_CAUSE_HALT; // RULE11 RULE17
      end
      if (do_wr) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = wwd_mapped(wr_addr) ? WWD_RESP_OKAY : WWD_RESP_SLVERR;
         // partial writes without lane 0 leave every 8-bit register alone
         if (wr_lane0) begin
            if (wwd_hit(wr_addr, WWD_ADDR_CTRL)) begin
               // prescaler is not restarted, so the first step comes early
               s_nxt.cnt = wd[6:0]; // RULE19 RULE12 RULE13
               s_nxt.activation_bit = s_r.activation_bit | wd[WWD_ACT_BIT]; // RULE8 RULE16
               // count before the write is compared; equal to the limit passes
               if (active_after && s_r.cnt > s_r.win) begin
                  trig = trig | WWD_CAUSE_WINDOW; // RULE4 RULE18
               end
               if (active_after && !wd[WWD_TOP_BIT]) begin
                  trig = trig | WWD_CAUSE_TOPBIT; // RULE7 RULE10
               end
            end
            if (wwd_hit(wr_addr, WWD_ADDR_WIN)) begin
               s_nxt.win = wd[6:0];
            end
            if (wwd_hit(wr_addr, WWD_ADDR_OPT)) begin
               s_nxt.hw_opt = wd[WWD_OPT_HW];
               s_nxt.halt_reset_option = wd[WWD_OPT_HALT];
               s_nxt.oscillator_irq_enable = wd[WWD_OPT_OIE];
            end
         end
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = 32'h0;
         s_nxt.rresp = WWD_RESP_OKAY;
         if (wwd_hit(s_axi_araddr, WWD_ADDR_CTRL)) begin
            s_nxt.rdata[7:0] = {s_r.activation_bit, s_r.cnt}; // RULE15
         end else if (wwd_hit(s_axi_araddr, WWD_ADDR_WIN)) begin
            s_nxt.rdata[6:0] = s_r.win;
         end else if (wwd_hit(s_axi_araddr, WWD_ADDR_OPT)) begin
            s_nxt.rdata[WWD_OPT_HW] = s_r.hw_opt;
            s_nxt.rdata[WWD_OPT_HALT] = s_r.halt_reset_option;
            s_nxt.rdata[WWD_OPT_OIE] = s_r.oscillator_irq_enable;
         end else if (wwd_hit(s_axi_araddr, WWD_ADDR_STAT)) begin
            s_nxt.rdata[WWD_STAT_ACT] = active;
            s_nxt.rdata[WWD_STAT_BUSY] = s_r.sys_rst;
            s_nxt.rdata[WWD_STAT_CAUSE+3:WWD_STAT_CAUSE] = s_r.cause;
         end else begin
            s_nxt.rresp = WWD_RESP_SLVERR;
         end
      end
      // a trigger during an ongoing reset pulse is absorbed by it
      case (s_r.fsm)
         WWD_RUN: begin
            if (trig != 4'h0) begin
               s_nxt.fsm = WWD_RST;
               s_nxt.hold = HOLD_LAST;
               s_nxt.sys_rst = 1'b1;
               s_nxt.cause = s_r.cause | trig;
            end
         end
         WWD_RST: begin
            if (s_r.hold == '0) begin
               s_nxt.fsm = WWD_RUN;
               s_nxt.sys_rst = 1'b0;
            end else begin
               s_nxt.hold = s_r.hold - HW'(1);
            end
         end
         default: begin
            s_nxt.fsm = WWD_RUN;
            s_nxt.sys_rst = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.fsm <= WWD_RUN;
         s_r.cnt <= WWD_CTRL_RST[6:0]; // RULE15
         s_r.activation_bit <= WWD_CTRL_RST[WWD_ACT_BIT]; // RULE16
         s_r.win <= WWD_WIN_RST;
         {s_r.oscillator_irq_enable, s_r.halt_reset_option, s_r.hw_opt} <= WWD_OPT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign sys_reset_req = s_r.sys_rst;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_count_step: assert property (tick && !ctrl_wr |=> s_r.cnt == $past(s_r.cnt) - 7'h01) // RULE1
      else $error("counter did not step by one on tick");
   a_tick_spacing: assert property (tick |=> (!tick)[*8]) // RULE1
      else $error("prescaler ticks too close");
   a_expiry_reset: assert property (tick && active && s_r.cnt == 7'h40 && s_r.fsm == WWD_RUN // RULE3
                                    |=> sys_reset_req && s_r.cause[0])
      else $error("no reset on counter expiry");
   a_idle_quiet: assert property (s_r.fsm == WWD_RUN && !active_after |=> !sys_reset_req) // RULE2
      else $error("reset while watchdog inactive");
   a_window_trip: assert property (ctrl_wr && active_after && s_r.cnt > s_r.win // RULE4
                                   && s_r.fsm == WWD_RUN |=> sys_reset_req)
      else $error("no reset on early reload");
   a_soft_reset: assert property (ctrl_wr && wd[7] && !wd[6] && s_r.fsm == WWD_RUN // RULE10
                                  |=> sys_reset_req)
      else $error("no software reset");
   a_act_sticky: assert property (s_r.activation_bit |=> s_r.activation_bit) // RULE16
      else $error("activation bit cleared without reset");
   a_hw_halt: assert property (s_r.hw_opt && s_r.halt_reset_option && !s_r.oscillator_irq_enable // RULE9
                               && halt_exec && s_r.fsm == WWD_RUN |=> sys_reset_req)
      else $error("hardware-active halt did not reset");
   a_halt_masked: assert property (halt_exec && s_r.oscillator_irq_enable && !tick && !do_wr // RULE17
                                   && s_r.fsm == WWD_RUN |=> !sys_reset_req)
      else $error("halt reset despite irq enable");
   a_reload_load: assert property (ctrl_wr |=> s_r.cnt == $past(wd[6:0])) // RULE19
      else $error("control write did not load counter");
   a_pulse_hold: assert property ($rose(sys_reset_req) |-> sys_reset_req[*8]) // RULE3
      else $error("reset pulse too short");

   // full pulse length rides on the hold counter, too long to unroll as a repetition
   a_pulse_start: assert property ($rose(sys_reset_req) // RULE3
                                   |-> s_r.fsm == WWD_RST && s_r.hold == HOLD_LAST)
      else $error("reset pulse started with a wrong hold count");
   a_pulse_count: assert property (s_r.fsm == WWD_RST && s_r.hold != '0 // RULE3
                                   |=> sys_reset_req && s_r.hold == $past(s_r.hold) - HW'(1))
      else $error("reset pulse hold count did not step");
   a_pulse_end: assert property (s_r.fsm == WWD_RST && s_r.hold == '0 // RULE3
                                 |=> !sys_reset_req && s_r.fsm == WWD_RUN)
      else $error("reset pulse did not end");
   a_cause_frozen: assert property (s_r.fsm == WWD_RST // RULE3
                                    |=> s_r.cause == $past(s_r.cause))
      else $error("cause changed during a reset pulse");
   a_no_step: assert property (!tick && !ctrl_wr |=> $stable(s_r.cnt)) // RULE1
      else $error("counter moved without tick or write");
   a_good_refresh: assert property (ctrl_wr && wd[7:6] == 2'h3 && s_r.cnt <= s_r.win // RULE18
                                    && s_r.fsm == WWD_RUN && !halt_exec && !(tick && s_r.cnt == WWD_CNT_EXPIRE)
                                    |=> !sys_reset_req)
      else $error("reset on a refresh inside the window");
   a_window_cause: assert property (ctrl_wr && active_after && s_r.cnt > s_r.win && s_r.fsm == WWD_RUN // RULE4
                                    |=> (s_r.cause & WWD_CAUSE_WINDOW) != 4'h0)
      else $error("early reload did not record its cause");
   a_halt_reset: assert property (halt_exec && active && s_r.halt_reset_option // RULE11
                                  && !s_r.oscillator_irq_enable && s_r.fsm == WWD_RUN
                                  |=> sys_reset_req && (s_r.cause & WWD_CAUSE_HALT) != 4'h0)
      else $error("no reset on halt with halt-reset option");
   a_halt_inactive: assert property (halt_exec && !active && !do_wr && s_r.fsm == WWD_RUN // RULE11
                                     |=> !sys_reset_req)
      else $error("halt reset while watchdog inactive");
   a_topbit_cause: assert property (ctrl_wr && active_after && !wd[WWD_TOP_BIT] && s_r.fsm == WWD_RUN // RULE7
                                    |=> (s_r.cause & WWD_CAUSE_TOPBIT) != 4'h0)
      else $error("top bit clear write did not record its cause");
   a_hw_topbit: assert property (s_r.hw_opt && ctrl_wr && !wd[WWD_ACT_BIT] && !wd[WWD_TOP_BIT] // RULE9
                                 && s_r.fsm == WWD_RUN |=> sys_reset_req)
      else $error("hardware-active top bit clear did not reset");
   a_act_off: assert property (!s_r.activation_bit && !ctrl_wr |=> !s_r.activation_bit) // RULE8
      else $error("activation bit set without a control write");
   a_ctrl_read: assert property (s_axi_arvalid && s_axi_arready && wwd_hit(s_axi_araddr, WWD_ADDR_CTRL) // RULE15
                                 |=> s_axi_rdata[7:0] == {$past(s_r.activation_bit), $past(s_r.cnt)})
      else $error("control read did not return activation bit and counter");
   a_window_load: assert property (do_wr && wr_lane0 && wwd_hit(wr_addr, WWD_ADDR_WIN) // RULE15
                                   |=> s_r.win == $past(wd[6:0]))
      else $error("window write did not load the limit");
   a_opt_load: assert property (do_wr && wr_lane0 && wwd_hit(wr_addr, WWD_ADDR_OPT) // RULE9
                                |=> s_r.hw_opt == $past(wd[WWD_OPT_HW]))
      else $error("option write did not load hardware activation");
   a_lane_skip: assert property (do_wr && !wr_lane0 // RULE15
                                 |=> $stable(s_r.win) && $stable(s_r.activation_bit) && $stable(s_r.hw_opt))
      else $error("write without lane 0 changed a register");

   c_expiry: cover property (tick && active && s_r.cnt == 7'h40);
   c_window: cover property (ctrl_wr && active_after && s_r.cnt > s_r.win);
   c_halt: cover property (halt_exec && active && s_r.halt_reset_option);
   c_good_refresh: cover property (ctrl_wr && wd[7:6] == 2'h3 && s_r.cnt <= s_r.win);
   c_soft_reset: cover property (ctrl_wr && wd[7:6] == 2'h2);
endmodule : wwd_top

// file: logic/wwd_pkg.sv
// constants, field layout and types of the window watchdog
// assumes a single 250 MHz clock and an AXI4-Lite register port
package wwd_pkg;
   // byte addresses of the register words
   localparam logic [3:0] WWD_ADDR_CTRL = 4'h0;
   localparam logic [3:0] WWD_ADDR_WIN = 4'h4;
   localparam logic [3:0] WWD_ADDR_OPT = 4'h8;
   localparam logic [3:0] WWD_ADDR_STAT = 4'hc;
   // field positions
   localparam int WWD_ACT_BIT = 7;
   localparam int WWD_TOP_BIT = 6;
   localparam int WWD_OPT_HW = 0;
   localparam int WWD_OPT_HALT = 1;
   localparam int WWD_OPT_OIE = 2;
   localparam int WWD_STAT_ACT = 0;
   localparam int WWD_STAT_BUSY = 1;
   localparam int WWD_STAT_CAUSE = 2;
   // cause bits
   localparam logic [3:0] WWD_CAUSE_EXPIRE = 4'h1;
   localparam logic [3:0] WWD_CAUSE_WINDOW = 4'h2;
   localparam logic [3:0] WWD_CAUSE_TOPBIT = 4'h4;
   localparam logic [3:0] WWD_CAUSE_HALT = 4'h8;
   // reset values
   localparam logic [7:0] WWD_CTRL_RST = 8'h7f;
   localparam logic [6:0] WWD_WIN_RST = 7'h7f;
   localparam logic [2:0] WWD_OPT_RST = 3'h0;
   localparam logic [6:0] WWD_CNT_EXPIRE = 7'h40;
   // timing
   localparam int WWD_PRESC_CYCLES = 16384;
   localparam int WWD_CLK_MHZ = 250;
   localparam int WWD_RST_HOLD_US = 30;
   localparam int WWD_RST_HOLD_CYCLES = WWD_RST_HOLD_US * WWD_CLK_MHZ;
   // bus answers
   localparam logic [1:0] WWD_RESP_OKAY = 2'h0;
   localparam logic [1:0] WWD_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      WWD_RUN = 2'h1,
      WWD_RST = 2'h2
   } wwd_fsm_t;
endpackage : wwd_pkg

// file: logic/wwd_prescaler.sv
// free-running prescaler giving one tick every DIV clock cycles
// assumes synchronous active-low reset; phase is not disturbed by software
`timescale 1ns/1ns
module wwd_prescaler
   import wwd_pkg::*;
#(
   parameter int unsigned DIV = WWD_PRESC_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic tick
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } wwd_presc_t;

   wwd_presc_t s_r;
   wwd_presc_t s_nxt;

   generate
      if (DIV < 2) begin : g_bad_div
         $error("prescaler divider below 2");
      end
   endgenerate

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.cnt == LAST) begin
         s_nxt.cnt = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule : wwd_prescaler

// file: verif/window_watchdog_tb.sv
// testbench for the window watchdog: AXI4-Lite register tasks and reset-request scenarios
// assumes the bench itself pulls aresetn after each reset request but the last, as the system would
`timescale 1ns/1ns
module window_watchdog_tb
   import wwd_pkg::*;
;
   localparam int DIV = 16;
   localparam int HOLD = 10;
   localparam logic [11:0] A_CTRL = 12'(WWD_ADDR_CTRL);
   localparam logic [11:0] A_WIN = 12'(WWD_ADDR_WIN);
   localparam logic [11:0] A_OPT = 12'(WWD_ADDR_OPT);
   localparam logic [11:0] A_STAT = 12'(WWD_ADDR_STAT);
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h0;
   logic [11:0] araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, halt_exec = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sys_reset_req;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, v;
   int error_cnt = 0;
   int n_tests = 0;
   int first, hi;

   wwd_top #(.ADDR_W(12), .PRESC_DIV(DIV), .RST_HOLD(HOLD)) wwd_top_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .halt_exec(halt_exec), .sys_reset_req(sys_reset_req)
   );

   initial begin
      forever #2 aclk = ~aclk;
   end

   task automatic close_out;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // handshakes sampled at the falling edge, where nothing is moving
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) break;
      end
      bready <= 1'b0;
      if (i == 40) begin
         error_cnt++;
         close_out();
      end
      chk("bresp", {30'h0, r}, {30'h0, er});
   endtask : bus_wr

   task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
      logic ta, tb;
      logic [1:0] r;
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tb = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tb) break;
      end
      rready <= 1'b0;
      if (i == 40) begin
         error_cnt++;
         close_out();
      end
      chk("rresp", {30'h0, r}, {30'h0, er});
   endtask : bus_rd

   task automatic watch(input int n);
      first = -1;
      hi = 0;
      for (int i = 0; i < n; i++) begin
         @(negedge aclk);
         if (sys_reset_req === 1'b1) begin
            if (first < 0) first = i;
            hi++;
         end
      end
   endtask : watch

   task automatic quiet(input int n);
      watch(n);
      chk("no_reset", 32'(hi), 32'h0);
   endtask : quiet

   // lo/hb bound the first cycle of the request, counted from the end of the trigger
   task automatic expect_rst(input logic [3:0] c, input int lo, input int hb);
      watch(hb + HOLD + 4);
      chk("reset_time", {31'h0, first >= lo && first <= hb}, 32'h1);
      bus_rd(A_STAT, v, WWD_RESP_OKAY);
      chk("cause", {28'h0, v[5:2]}, {28'h0, c});
   endtask : expect_rst

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : do_reset

   task automatic halt_pulse;
      @(posedge aclk);
      halt_exec <= 1'b1;
      @(posedge aclk);
      halt_exec <= 1'b0;
   endtask : halt_pulse

   initial begin
      do_reset();
      bus_rd(A_CTRL, v, WWD_RESP_OKAY);
      chk("ctrl_rst", v, 32'h7f);
      bus_rd(A_WIN, v, WWD_RESP_OKAY);
      chk("win_rst", v, 32'h7f);
      bus_rd(A_STAT, v, WWD_RESP_OKAY);
      chk("stat_rst", v, 32'h0);
      bus_rd(12'h010, v, WWD_RESP_SLVERR);
      chk("unmapped", v, 32'h0);
      bus_wr(12'h010, 32'hff, WWD_RESP_SLVERR);
      // inactive counter still falls, about five ticks by now
      repeat (80) @(posedge aclk);
      bus_rd(A_CTRL, v, WWD_RESP_OKAY);
      chk("free_run", {31'h0, v >= 32'h79 && v <= 32'h7b}, 32'h1);
      bus_wr(A_CTRL, 32'h41, WWD_RESP_OKAY);
      quiet(3 * DIV + 8);
      bus_wr(A_CTRL, 32'h3f, WWD_RESP_OKAY);
      quiet(8);
      bus_rd(A_STAT, v, WWD_RESP_OKAY);
      chk("stat_inactive", v, 32'h0);
      bus_wr(A_CTRL, 32'h70, WWD_RESP_OKAY);
      bus_rd(A_CTRL, v, WWD_RESP_OKAY);
      chk("reload", {31'h0, v >= 32'h6f && v <= 32'h70}, 32'h1);
      bus_wr(A_CTRL, 32'hff, WWD_RESP_OKAY);
      bus_rd(A_STAT, v, WWD_RESP_OKAY);
      chk("act_set", {31'h0, v[0]}, 32'h1);
      bus_wr(A_CTRL, 32'h7f, WWD_RESP_OKAY);
      bus_rd(A_STAT, v, WWD_RESP_OKAY);
      chk("act_sticks", {31'h0, v[0]}, 32'h1);
      bus_wr(A_CTRL, 32'hc5, WWD_RESP_OKAY);
      quiet(20);
      // three decrements from 42h reach 3fh
      bus_wr(A_CTRL, 32'hc2, WWD_RESP_OKAY);
      expect_rst(WWD_CAUSE_EXPIRE, 2 * DIV - 2, 3 * DIV + 2);
      chk("hold_len", {31'h0, hi >= HOLD && hi <= HOLD + 1}, 32'h1);
      do_reset();
      bus_wr(A_WIN, 32'h50, WWD_RESP_OKAY);
      bus_rd(A_WIN, v, WWD_RESP_OKAY);
      chk("win_wr", v, 32'h50);
      wstrb <= 4'he;
      bus_wr(A_WIN, 32'h11, WWD_RESP_OKAY);
      wstrb <= 4'hf;
      bus_rd(A_WIN, v, WWD_RESP_OKAY);
      chk("lane_skip", v, 32'h50);
      bus_wr(A_CTRL, 32'hff, WWD_RESP_OKAY);
      expect_rst(WWD_CAUSE_WINDOW, 0, 3);
      do_reset();
      bus_wr(A_CTRL, 32'hbf, WWD_RESP_OKAY);
      bus_rd(A_STAT, v, WWD_RESP_OKAY);
      chk("stat_busy", v, 32'h13);
      expect_rst(WWD_CAUSE_TOPBIT, 0, 3);
      do_reset();
      bus_wr(A_OPT, 32'h1, WWD_RESP_OKAY);
      bus_rd(A_STAT, v, WWD_RESP_OKAY);
      chk("hw_active", {31'h0, v[0]}, 32'h1);
      bus_wr(A_CTRL, 32'h3f, WWD_RESP_OKAY);
      expect_rst(WWD_CAUSE_TOPBIT, 0, 3);
      do_reset();
      bus_wr(A_OPT, 32'h2, WWD_RESP_OKAY);
      halt_pulse();
      quiet(10);
      bus_wr(A_OPT, 32'h6, WWD_RESP_OKAY);
      bus_rd(A_OPT, v, WWD_RESP_OKAY);
      chk("opt_rd", v, 32'h6);
      bus_wr(A_CTRL, 32'hff, WWD_RESP_OKAY);
      halt_pulse();
      quiet(10);
      bus_wr(A_OPT, 32'h2, WWD_RESP_OKAY);
      bus_wr(A_CTRL, 32'hfe, WWD_RESP_OKAY);
      halt_pulse();
      expect_rst(WWD_CAUSE_HALT, 0, 3);
      do_reset();
      bus_wr(A_OPT, 32'h3, WWD_RESP_OKAY);
      halt_pulse();
      expect_rst(WWD_CAUSE_HALT, 0, 3);
      close_out();
   end
endmodule : window_watchdog_tb
